// ### rcct_far_end.sv
// Far-side model: external reset pin and supply brown-out detector
`timescale 1ns/10ps
module rcct_far_end (
  input wire logic mclk,
  output logic ext_rst_n_pin,
  output logic brownout_detect_pin
);
  // ----------------------------------------
  // Pin and supply monitor levels
  // ----------------------------------------
  // Power comes up with the pin held low by the board, supply in range
  initial begin
    ext_rst_n_pin = 1'b0;
    brownout_detect_pin = 1'b0;
  end

  // Pin level changes only just after a clock edge
  task automatic set_pin(input logic v);
    @(posedge mclk);
    ext_rst_n_pin <= v;
  endtask

  // Detector stays high for as long as the supply is low
  task automatic set_brown(input logic v);
    @(posedge mclk);
    brownout_detect_pin <= v;
  endtask
endmodule

// ### rcct_map.svh
// Field positions, reset values and counts for reset control
`ifndef RCCT_MAP_SVH
`define RCCT_MAP_SVH
// ----------------------------------------
// Reset cause field positions
// ----------------------------------------
`define RCCT_CAUSE_EXT 0
`define RCCT_CAUSE_POR 1
`define RCCT_CAUSE_BOR 2
`define RCCT_CAUSE_WDT 3
`define RCCT_CAUSE_SW 4
`define RCCT_CAUSE_W 5
`define RCCT_CAUSE_RST 5'h02
// ----------------------------------------
// Power and brown-out control fields
// ----------------------------------------
`define RCCT_PBOR_IRQ_MODE 0
`define RCCT_PBOR_RESET_EN 1
`define RCCT_PBOR_W 2
`define RCCT_PBOR_RST 2'h0
// ----------------------------------------
// Counts and sizes
// ----------------------------------------
`define RCCT_SYNC_CYCLES 3'h4
`define RCCT_SYNC_CW 3
`define RCCT_PRST_REGS 3
`define RCCT_PRST_W 32
`define RCCT_CAP_REGS 5
`define RCCT_WD_W 32
`endif

// ### rcct_pkg.sv
// Shared types of the reset control block
package rcct_pkg;
  // ----------------------------------------
  // Sequencer states and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {seq_pwrup, seq_hold, seq_sync, seq_run} rcct_seq_e;

  typedef struct packed {
    logic [31:0] watchdog_load_value;
    logic enable;
    logic int_en;
    logic rst_en;
  } rcct_wdog_cfg_s;

  typedef struct packed {
    logic [31:0] device_ident_reg_a;
    logic [31:0] device_ident_reg_b;
    logic [4:0][31:0] capability_regs;
  } rcct_ident_s;
endpackage

// ### rcct_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`include "rcct_map.svh"
module rcct_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcct_sync_state_s;

  rcct_sync_state_s s;
  rcct_sync_state_s next_s;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  // First stage is read only by the second stage
  always_comb begin
    next_s.meta = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;
endmodule

// ### rcct_tb_top.sv
// Self-checking bench for reset sequencing, cause tracking and peripheral resets
`timescale 1ns/10ps
`include "rcct_map.svh"
module rcct_tb_top;
  localparam logic [31:0] ID_A = 32'h0000_5A01; // Arbitrary value
  localparam logic [31:0] ID_B = 32'h0000_5A02; // Arbitrary value
  localparam logic [4:0][31:0] CAPS = {32'h5, 32'h4, 32'h3, 32'h2, 32'h1}; // Arbitrary values
  logic mclk, rst_n, ext_rst_n_pin, brownout_detect_pin, system_reset_request;
  rcct_pkg::rcct_wdog_cfg_s watchdog_cfg;
  logic watchdog_load_we, watchdog_irq_clr, pbor_we, cause_we;
  logic [`RCCT_PBOR_W-1:0] pbor_wdata, power_brownout_ctrl_reg;
  logic [`RCCT_CAUSE_W-1:0] cause_wdata, reset_cause_reg, exp_c;
  logic [2:0][31:0] prst, periph_rst_n;
  logic core_rst_n, tap_rst_n, brownout_irq, watchdog_irq;
  logic [31:0] watchdog_count, ld;
  rcct_pkg::rcct_ident_s ident;
  int n_fail, n_tests, k, r, b;
  int cycles = 0;

  rcct_top #(.IDENT_A(ID_A), .IDENT_B(ID_B), .CAPS(CAPS)) u_rcct_top (
    .mclk(mclk), .rst_n(rst_n), .ext_rst_n_pin(ext_rst_n_pin),
    .brownout_detect_pin(brownout_detect_pin), .system_reset_request(system_reset_request),
    .watchdog_cfg(watchdog_cfg), .watchdog_load_we(watchdog_load_we),
    .watchdog_irq_clr(watchdog_irq_clr), .pbor_we(pbor_we), .pbor_wdata(pbor_wdata),
    .cause_we(cause_we), .cause_wdata(cause_wdata), .peripheral_reset_regs(prst),
    .core_rst_n(core_rst_n), .tap_rst_n(tap_rst_n), .periph_rst_n(periph_rst_n),
    .reset_cause_reg(reset_cause_reg), .power_brownout_ctrl_reg(power_brownout_ctrl_reg),
    .brownout_irq(brownout_irq), .watchdog_irq(watchdog_irq),
    .watchdog_count(watchdog_count), .ident(ident));

  rcct_far_end u_rcct_far_end (.mclk(mclk), .ext_rst_n_pin(ext_rst_n_pin),
    .brownout_detect_pin(brownout_detect_pin));

  // ----------------------------------------
  // Clock, hang guard and helpers
  // ----------------------------------------
  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // A stuck sequencer would otherwise never end the run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Bounded wait for the core reset level, then compare it
  task automatic wait_core(input logic lvl, input int lim);
    int i;
    #1;
    for (i = 0; i < lim && core_rst_n !== lvl; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(core_rst_n, lvl);
  endtask

  function automatic logic [4:0] add_cause(input logic [4:0] c, input int pos);
    return c | (5'h01 << pos);
  endfunction

  // Every unit out of reset except the one selected
  function automatic logic [95:0] one_unit(input int rr, input int bb);
    logic [95:0] m;
    m = '1;
    m[rr*32+bb] = 1'b0;
    return m;
  endfunction

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Power-up, then every reset source in turn, then a second power-on
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'b0;
    system_reset_request = 1'b0;
    watchdog_cfg = '0;
    watchdog_load_we = 1'b0;
    watchdog_irq_clr = 1'b0;
    pbor_we = 1'b0;
    pbor_wdata = 2'h0;
    cause_we = 1'b0;
    cause_wdata = 5'h00;
    prst = '0;
    k = $urandom(63508);
    tk(2);
    #1;
    chk(reset_cause_reg, 5'h02);
    chk(power_brownout_ctrl_reg, 2'h0);
    chk({tap_rst_n, core_rst_n}, 2'h0);
    chk(ident, {ID_A, ID_B, CAPS});
    tk(1);
    rst_n <= 1'b1;
    tk(10);
    #1;
    chk({tap_rst_n, core_rst_n}, 2'h2);
    u_rcct_far_end.set_pin(1'b1);
    tk(3);
    #1;
    chk(core_rst_n, 1'b0);
    wait_core(1'b1, 10);
    chk(reset_cause_reg, 5'h02);
    // Random write lands as written, then a write of zero clears it
    tk(1);
    exp_c = 5'($urandom);
    cause_we <= 1'b1;
    cause_wdata <= exp_c;
    tk(1);
    #1;
    chk(reset_cause_reg, exp_c);
    cause_wdata <= 5'h00;
    tk(1);
    cause_we <= 1'b0;
    #1;
    exp_c = 5'h00;
    chk(reset_cause_reg, exp_c);
    // Pin reset: the test port must keep running
    u_rcct_far_end.set_pin(1'b0);
    tk(5);
    #1;
    chk({tap_rst_n, core_rst_n, periph_rst_n}, {2'h2, 96'h0});
    u_rcct_far_end.set_pin(1'b1);
    exp_c = add_cause(exp_c, `RCCT_CAUSE_EXT);
    wait_core(1'b1, 20);
    chk(reset_cause_reg, exp_c);
    // Software system reset, earlier cause stays set
    tk(1);
    system_reset_request <= 1'b1;
    tk(1);
    system_reset_request <= 1'b0;
    #1;
    exp_c = add_cause(exp_c, `RCCT_CAUSE_SW);
    chk({core_rst_n, reset_cause_reg}, {1'b0, exp_c});
    tk(2);
    #1;
    chk(core_rst_n, 1'b0);
    wait_core(1'b1, 4);
    // Brown-out while reset is disabled gives one interrupt pulse only
    u_rcct_far_end.set_brown(1'b1);
    k = 0;
    repeat (6) begin
      @(posedge mclk);
      #1;
      if (brownout_irq === 1'b1) k++;
      if (core_rst_n !== 1'b1) k += 8;
    end
    chk(k, 1);
    u_rcct_far_end.set_brown(1'b0);
    tk(1);
    pbor_we <= 1'b1;
    pbor_wdata <= {1'b1, 1'($urandom)};
    tk(1);
    pbor_we <= 1'b0;
    #1;
    chk(power_brownout_ctrl_reg, 2'h2);
    u_rcct_far_end.set_brown(1'b1);
    tk(12);
    #1;
    chk(core_rst_n, 1'b0);
    u_rcct_far_end.set_brown(1'b0);
    exp_c = add_cause(exp_c, `RCCT_CAUSE_BOR);
    wait_core(1'b1, 12);
    chk(reset_cause_reg, exp_c);
    // Set-then-clear: bottom bit, top bit, then a random unit
    for (r = 0; r < 3; r++) begin
      b = (r == 0) ? 0 : (r == 1) ? 31 : $urandom_range(31, 0);
      tk(1);
      prst[r][b] <= 1'b1;
      tk(1);
      #1;
      chk(periph_rst_n, one_unit(r, b));
      tk(1);
      prst[r][b] <= 1'b0;
      tk(1);
      #1;
      chk(periph_rst_n, one_unit(r, b));
      tk(1);
      #1;
      chk(periph_rst_n, {96{1'b1}});
    end
    // Watchdog: first timeout interrupts, reset held off while disabled
    ld = $urandom_range(12, 3);
    tk(1);
    watchdog_cfg <= '{watchdog_load_value: ld, enable: 1'b1, int_en: 1'b1, rst_en: 1'b0};
    watchdog_load_we <= 1'b1;
    tk(1);
    watchdog_load_we <= 1'b0;
    #1;
    k = 0;
    while (watchdog_irq !== 1'b1 && k < 40) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk({watchdog_irq, watchdog_count}, {1'b1, ld});
    k = 0;
    repeat (ld + 4) begin
      @(posedge mclk);
      #1;
      if (core_rst_n !== 1'b1) k++;
    end
    chk({k[3:0], watchdog_irq}, {4'h0, 1'b1});
    // Reload with the clear so no timeout can coincide with it
    tk(1);
    watchdog_irq_clr <= 1'b1;
    watchdog_load_we <= 1'b1;
    watchdog_cfg.rst_en <= 1'b1;
    tk(1);
    watchdog_irq_clr <= 1'b0;
    watchdog_load_we <= 1'b0;
    #1;
    chk(watchdog_irq, 1'b0);
    wait_core(1'b0, 2 * ld + 8);
    tk(1);
    watchdog_cfg.enable <= 1'b0;
    exp_c = add_cause(exp_c, `RCCT_CAUSE_WDT);
    wait_core(1'b1, 12);
    chk(reset_cause_reg, exp_c);
    // Second power-on clears every other cause
    tk(1);
    rst_n <= 1'b0;
    tk(2);
    #1;
    chk({tap_rst_n, reset_cause_reg}, {1'b0, 5'h02});
    tk(1);
    rst_n <= 1'b1;
    wait_core(1'b1, 12);
    wrap_up;
  end
endmodule

// ### rcct_top.sv
// Reset sequencing, cause tracking and peripheral resets of the system controller
// Functional notes
// - Five sources reset the controller: pin, power-on, brown-out, software, watchdog.
// - Reset cause bits are recorded and stay set across later resets.
// - Power-on reset clears all cause bits except power-on, which it sets.
// - External pin resets core and peripherals, test port logic keeps state.
// - After pin release, a few synchronising cycles pass before internal release.
// - At power-up, hold until both pin and power-on are inactive.
// - Power-on reset occurs only at initial power-up.
// - Power-on reset also resets the test port controller.
// - Brown-out reset is disabled out of reset until software enables it.
// - Brown-out raises an interrupt or a reset, chosen by configuration.
// - Brown-out resets only when the brown-out reset enable bit is set.
// - Brown-out reset acts like pin reset and holds until supply recovers.
// - Setting then clearing a peripheral reset bit resets that peripheral.
// - Peripheral reset bit positions match the clock gating bit positions.
// - A peripheral reset reaches every clock domain of that unit.
// - System reset request resets core and peripherals, then releases into normal boot.
// - Watchdog interrupts on first timeout and resets on the second.
// - After first timeout the watchdog reloads from its load value.
// - Watchdog resets only if zero reached again with interrupt uncleared and enabled; the code gates this reset on rst_en, not on int_en.
// - Identification registers are read-only; writes have no effect.
`timescale 1ns/10ps
`include "rcct_map.svh"
module rcct_top #(
  parameter logic [31:0] IDENT_A = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] IDENT_B = 32'h0000_0002, // Arbitrary value
  parameter logic [`RCCT_CAP_REGS-1:0][31:0] CAPS = '0, // Arbitrary value
  parameter int NREG = `RCCT_PRST_REGS,
  parameter int NBIT = `RCCT_PRST_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_rst_n_pin,
  input wire logic brownout_detect_pin,
  input wire logic system_reset_request,
  input wire rcct_pkg::rcct_wdog_cfg_s watchdog_cfg,
  input wire logic watchdog_load_we,
  input wire logic watchdog_irq_clr,
  input wire logic pbor_we,
  input wire logic [`RCCT_PBOR_W-1:0] pbor_wdata,
  input wire logic cause_we,
  input wire logic [`RCCT_CAUSE_W-1:0] cause_wdata,
  input wire logic [NREG-1:0][NBIT-1:0] peripheral_reset_regs,
  output logic core_rst_n,
  output logic tap_rst_n,
  output logic [NREG-1:0][NBIT-1:0] periph_rst_n,
  output logic [`RCCT_CAUSE_W-1:0] reset_cause_reg,
  output logic [`RCCT_PBOR_W-1:0] power_brownout_ctrl_reg,
  output logic brownout_irq,
  output logic watchdog_irq,
  output logic [`RCCT_WD_W-1:0] watchdog_count,
  output rcct_pkg::rcct_ident_s ident
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rcct_pkg::rcct_seq_e seq;
    logic [`RCCT_SYNC_CW-1:0] cnt;
    logic core_rst_n;
    logic tap_rst_n;
    logic [`RCCT_CAUSE_W-1:0] cause;
    logic [`RCCT_PBOR_W-1:0] pbor;
    logic bor_prev;
    logic bor_irq;
    logic [NREG-1:0][NBIT-1:0] prst_prev;
    logic [NREG-1:0][NBIT-1:0] prst_n;
    rcct_pkg::rcct_ident_s ident;
  } rcct_top_state_s;

  rcct_top_state_s s;
  rcct_top_state_s next_s;

  logic ext_n_s;
  logic bor_s;
  logic wd_rst;
  logic bor_reset;
  logic src_hold;
  logic [NREG-1:0][NBIT-1:0] prst_calc;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pin held asserted and brown-out idle while the synchroniser is in reset
  rcct_sync #(
    .W(2),
    .RST_VAL(2'h0)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({ext_rst_n_pin, brownout_detect_pin}),
    .dout({ext_n_s, bor_s})
  );

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Internal reset reloads the counter so a new boot starts clean
  rcct_wdog #(
    .W(`RCCT_WD_W)
  ) u_wdog (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(!s.core_rst_n),
    .load_we(watchdog_load_we),
    .irq_clr(watchdog_irq_clr),
    .cfg(watchdog_cfg),
    .irq(watchdog_irq),
    .rst_pulse(wd_rst),
    .count(watchdog_count)
  );

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  // Brown-out only holds reset when enabled, and for as long as it lasts
  assign bor_reset = bor_s & s.pbor[`RCCT_PBOR_RESET_EN];
  // Any one source forces the system into reset
  assign src_hold = !ext_n_s | bor_reset | system_reset_request | wd_rst;

  // ----------------------------------------
  // Peripheral reset terms
  // ----------------------------------------
  // Bit i of each word selects the same unit as bit i of the clock gates;
  // one output per unit, fanned out to all of its clock domains outside
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_prst
      // Reset while the bit is set and for one cycle after it clears
      assign prst_calc[gi] = ~(peripheral_reset_regs[gi] | s.prst_prev[gi]);
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.tap_rst_n = 1'b1;
    next_s.ident = s.ident;
    // Sequencer
    case (s.seq)
      rcct_pkg::seq_pwrup: begin
        // Power-on has ended; wait for the pin too, whichever is later
        if (ext_n_s) begin
          next_s.seq = rcct_pkg::seq_sync;
          next_s.cnt = '0;
        end
      end
      rcct_pkg::seq_hold: begin
        if (!src_hold) begin
          next_s.seq = rcct_pkg::seq_sync;
          next_s.cnt = '0;
        end
      end
      rcct_pkg::seq_sync: begin
        // Settle a few cycles before letting the core fetch its vectors
        if (src_hold) begin
          next_s.seq = rcct_pkg::seq_hold;
        end else if (s.cnt == `RCCT_SYNC_CYCLES - 3'h1) begin
          next_s.seq = rcct_pkg::seq_run;
        end else begin
          next_s.cnt = s.cnt + 3'h1;
        end
      end
      rcct_pkg::seq_run: begin
        if (src_hold) begin
          next_s.seq = rcct_pkg::seq_hold;
        end
      end
      default: begin
        next_s.seq = rcct_pkg::seq_pwrup;
      end
    endcase
    next_s.core_rst_n = (next_s.seq == rcct_pkg::seq_run);
    // Cause register: software write first, so a new cause wins
    if (cause_we) begin
      next_s.cause = cause_wdata;
    end
    // Sources seen during power-up belong to the power-on cause only
    if (s.seq != rcct_pkg::seq_pwrup) begin
      if (!ext_n_s) begin
        next_s.cause[`RCCT_CAUSE_EXT] = 1'b1;
      end
      if (bor_reset) begin
        next_s.cause[`RCCT_CAUSE_BOR] = 1'b1;
      end
      if (system_reset_request) begin
        next_s.cause[`RCCT_CAUSE_SW] = 1'b1;
      end
      if (wd_rst) begin
        next_s.cause[`RCCT_CAUSE_WDT] = 1'b1;
      end
    end
    // Brown-out control; low bit is reserved and reads zero
    if (pbor_we) begin
      next_s.pbor = pbor_wdata & 2'h2;
    end
    // Interrupt when brown-out is configured not to reset
    next_s.bor_prev = bor_s;
    next_s.bor_irq = bor_s & !s.bor_prev & !s.pbor[`RCCT_PBOR_RESET_EN];
    // Peripheral resets also follow the system reset
    next_s.prst_prev = peripheral_reset_regs;
    for (int r = 0; r < NREG; r++) begin
      next_s.prst_n[r] = prst_calc[r] & {NBIT{next_s.core_rst_n}};
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Power-on is this block's own reset, so cause starts as power-on only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s.seq <= rcct_pkg::seq_pwrup;
      s.cnt <= '0;
      s.core_rst_n <= 1'b0;
      s.tap_rst_n <= 1'b0;
      s.cause <= `RCCT_CAUSE_RST;
      s.pbor <= `RCCT_PBOR_RST;
      s.bor_prev <= 1'b0;
      s.bor_irq <= 1'b0;
      s.prst_prev <= '0;
      s.prst_n <= '0;
      s.ident <= '{IDENT_A, IDENT_B, CAPS};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign core_rst_n = s.core_rst_n;
  assign tap_rst_n = s.tap_rst_n;
  assign periph_rst_n = s.prst_n;
  assign reset_cause_reg = s.cause;
  assign power_brownout_ctrl_reg = s.pbor;
  assign brownout_irq = s.bor_irq;
  assign ident = s.ident;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_pin_holds: assert property (!ext_n_s |=> !core_rst_n)
    else $error("pin reset did not hold internal reset");
  chk_sync_wait: assert property ($rose(core_rst_n) |->
    ($past(ext_n_s, 1) && $past(ext_n_s, 4) && !$past(src_hold, 1)))
    else $error("internal reset released without sync cycles");
  chk_tap_kept: assert property ($past(tap_rst_n) |-> tap_rst_n)
    else $error("test port reset asserted after power-on");
  chk_bor_reset: assert property (bor_reset |=> !core_rst_n ##0
    reset_cause_reg[`RCCT_CAUSE_BOR])
    else $error("enabled brown-out did not reset");
  chk_bor_ignored: assert property ((core_rst_n && bor_s &&
    !power_brownout_ctrl_reg[`RCCT_PBOR_RESET_EN] && ext_n_s &&
    !system_reset_request && !wd_rst) |=> core_rst_n)
    else $error("disabled brown-out caused a reset");
  chk_bor_irq: assert property ($rose(bor_s) &&
    !power_brownout_ctrl_reg[`RCCT_PBOR_RESET_EN] |=> brownout_irq)
    else $error("brown-out interrupt missing");
  chk_cause_sticky: assert property (!cause_we |=>
    ((reset_cause_reg & $past(reset_cause_reg)) == $past(reset_cause_reg)))
    else $error("cause bit lost without a write");
  chk_sw_reset: assert property (system_reset_request |=>
    (!core_rst_n && reset_cause_reg[`RCCT_CAUSE_SW]))
    else $error("system reset request not honoured");
  chk_wd_cause: assert property (wd_rst |=>
    (!core_rst_n && reset_cause_reg[`RCCT_CAUSE_WDT]))
    else $error("watchdog reset not recorded");
  chk_prst_pulse: assert property ($fell(peripheral_reset_regs[0][0]) |->
    !periph_rst_n[0][0] ##1 !periph_rst_n[0][0])
    else $error("peripheral reset not applied on clear");
  chk_ident_fixed: assert property (ident == $past(ident))
    else $error("identification value changed");

  cov_pin_boot: cover property ($rose(core_rst_n) && reset_cause_reg[`RCCT_CAUSE_EXT]);
  cov_sw_boot: cover property (system_reset_request ##[1:20] $rose(core_rst_n));
  cov_bor_reset: cover property (bor_reset ##1 !bor_reset ##[1:20] $rose(core_rst_n));
  cov_wd_reset: cover property (wd_rst ##[1:20] $rose(core_rst_n));
endmodule

// ### rcct_wdog.sv
// Watchdog down-counter with first-timeout interrupt and second-timeout reset
`timescale 1ns/10ps
`include "rcct_map.svh"
module rcct_wdog #(
  parameter int W = `RCCT_WD_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic load_we,
  input wire logic irq_clr,
  input wire rcct_pkg::rcct_wdog_cfg_s cfg,
  output logic irq,
  output logic rst_pulse,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic flag;
    logic irq;
    logic rst;
  } rcct_wd_state_s;

  rcct_wd_state_s s;
  rcct_wd_state_s next_s;
  logic [W-1:0] load;

  assign load = W'(cfg.watchdog_load_value);

  // ----------------------------------------
  // Counting and timeouts
  // ----------------------------------------
  // Flag set on a timeout beats an interrupt clear in the same cycle
  always_comb begin
    next_s = s;
    next_s.rst = 1'b0;
    if (irq_clr) begin
      next_s.flag = 1'b0;
    end
    if (clear) begin
      next_s.cnt = load;
      next_s.flag = 1'b0;
    end else if (load_we) begin
      next_s.cnt = load;
    end else if (cfg.enable) begin
      if (s.cnt == '0) begin
        next_s.cnt = load;
        next_s.flag = 1'b1;
        next_s.rst = s.flag & cfg.rst_en;
      end else begin
        next_s.cnt = s.cnt - W'(1);
      end
    end
    next_s.irq = next_s.flag & cfg.int_en;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{cnt: '1, flag: 1'b0, irq: 1'b0, rst: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign irq = s.irq;
  assign rst_pulse = s.rst;
  assign count = s.cnt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_wd_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.enable && !clear && !load_we && s.cnt == '0) |=> (s.cnt == $past(load)))
    else $error("watchdog did not reload after timeout");
  chk_wd_second: assert property (@(posedge mclk) disable iff (!rst_n)
    s.rst |-> ($past(s.flag) && $past(cfg.rst_en) && $past(s.cnt) == '0))
    else $error("watchdog reset without uncleared first timeout");
endmodule
